// File: core/pps_pkg.sv
// Constants shared by the port PHY control and status register bank
// Contract
// (RULE1) Writing one to diagnostic bit 12 starts the cable test; hardware clears it when done.
// (RULE2) Result field bits 14-13: 00 normal, 01 open, 10 short, 11 test failed.
// (RULE3) Diagnostic bit 15 is set when the short lies within about ten meters.
// (RULE4) Bits 8-0 hold the fault count; distance is about count times 0.4 m.
// (RULE5) Diagnostic bit 11 forces link pass; clearing restores normal link detection.
// (RULE6) Diagnostic bit 10 resets to one, power saving off; zero enables it.
// (RULE7) Diagnostic bit 9 loops line receive back to transmit at PMD/PMA level.
// (RULE8) Control bit 15 turns all four port LEDs off by driving them high.
// (RULE9) Control bit 14 disables the transmitter, bit 11 powers the PHY down.
// (RULE10) Writing one to control bit 13 restarts auto-negotiation.
// (RULE11) Control bit 12 disables far-end fault detection and pattern transmission.
// (RULE12) Control bit 10 disables auto crossover; bit 9 forces MDIX only then.
// (RULE13) Control bit 7 resets to one; clear takes speed and duplex from forced bits.
// (RULE14) With negotiation off, bit 6 selects 100 Mbps when set, else 10 Mbps.
// (RULE15) Bit 5 selects full duplex; used when negotiation is off or failed.
// (RULE16) Control bits 4-0 reset to one and gate each advertised ability.
// (RULE17) Status bit 15 is writable and selects between two crossover algorithms.
// (RULE18) Status bit 13 shows reversed polarity, bit 7 shows MDIX mode.
// (RULE19) Status bits 12 and 11 show receive and transmit flow control active.
// (RULE20) Status bit 10 shows 100 Mbps speed, bit 9 shows full duplex.
// (RULE21) Status bit 8 far-end fault, bit 6 negotiation done, bit 5 link good.
// (RULE22) Status bits 4-0 show the partner's pause, 100F, 100H, 10F, 10H abilities.
// (RULE23) Diagnostic and special-control views share one state; writes through either affect both.
// (RULE24) Writes to read-only or reserved bits are ignored; reserved range reads zero.
package pps_pkg;
  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_CABLE_VIEW = 14'h04F0;
  localparam logic [13:0] IDX_SPECIAL_VIEW = 14'h04F2;
  localparam logic [13:0] IDX_DIAG = 14'h0510;
  localparam logic [13:0] IDX_CONTROL = 14'h0512;
  localparam logic [13:0] IDX_STATUS = 14'h0514;
  localparam logic [13:0] IDX_RSVD_LO = 14'h0516;
  localparam logic [13:0] IDX_RSVD_HI = 14'h0560;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  // Reset values
  localparam logic [15:0] DIAG_RESET = 16'h0400;
  localparam logic [15:0] CONTROL_RESET = 16'h009F;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam logic [3:0] LED_ALL_OFF = 4'hF;
  // Diagnostic register fields
  localparam int DIAG_START = 12;
  localparam int DIAG_FORCE_LINK = 11;
  localparam int DIAG_PWR_SAVE = 10;
  localparam int DIAG_LOOPBACK = 9;
  localparam int FAULT_W = 9;
  // Cable test view and special control view fields
  localparam int CABLE_VIEW_START = 15;
  localparam int SPECIAL_FORCE_LINK = 3;
  localparam int SPECIAL_PWR_SAVE = 2;
  localparam int SPECIAL_LOOPBACK = 1;
  // Control register fields
  localparam int CTRL_LED_OFF = 15;
  localparam int CTRL_TX_DISABLE = 14;
  localparam int CTRL_RESTART_AN = 13;
  localparam int CTRL_FEF_DISABLE = 12;
  localparam int CTRL_POWER_DOWN = 11;
  localparam int CTRL_MDIX_DISABLE = 10;
  localparam int CTRL_FORCE_MDIX = 9;
  localparam int CTRL_AN_ENABLE = 7;
  localparam int CTRL_FORCE_SPEED = 6;
  localparam int CTRL_FORCE_DUPLEX = 5;
  localparam int ADV_MSB = 4;
  localparam int ADV_W = 5;
  localparam logic [4:0] ADV_ALL = 5'h1F;
  // Status register fields
  localparam int STAT_XOVER_SEL = 15;
  // Cable diagnostic result codes
  localparam logic [1:0] CABLE_NORMAL = 2'h0;
  localparam logic [1:0] CABLE_OPEN = 2'h1;
  localparam logic [1:0] CABLE_SHORT = 2'h2;
  localparam logic [1:0] CABLE_FAILED = 2'h3;
endpackage

// File: core/pps_sc_bit.sv
// Self-clearing control bit: set by software, cleared by hardware, set wins
`timescale 1ns/1ps
`default_nettype none
module pps_sc_bit
  import pps_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Set and clear requests
  input wire logic setReq,
  input wire logic clearReq,
  // Bit value
  output logic bitOut
);
  typedef struct packed {
    logic bitValue;
  } pps_sc_state_t;
  pps_sc_state_t state_reg;
  pps_sc_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    // Set beats a clear in the same cycle so no start is lost
    if (setReq)
    begin
      state_next.bitValue = 1'b1;
    end
    else if (clearReq)
    begin
      state_next.bitValue = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign bitOut = state_reg.bitValue;

  setWins_a: // RULE1
  assert property (@(posedge clk_sys) disable iff (reset) setReq |=> bitOut)
    else $error("self-clearing bit lost a set");
endmodule
`default_nettype wire

// File: core/pps_apb_front.sv
// APB slave timing: no wait state, registered read data and error
`timescale 1ns/1ps
`default_nettype none
module pps_apb_front
  import pps_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,
  // Register side
  input wire logic [DATA_W-1:0] readData,
  input wire logic mapped,
  output logic writeEn
);
  typedef struct packed {
    logic ready;
    logic err;
    logic [DATA_W-1:0] data;
  } pps_apb_state_t;
  pps_apb_state_t state_reg;
  pps_apb_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.ready = 1'b0;
    // Sample in setup so read data leaves a flip-flop in the access phase
    if (psel && !penable)
    begin
      state_next.ready = 1'b1;
      state_next.err = !mapped;
      state_next.data = (mapped && !pwrite) ? readData : READ_ZERO;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign pready = state_reg.ready;
  assign pslverr = state_reg.err;
  assign prdata = state_reg.data;
  // Unmapped writes are dropped here as well as answered with an error
  assign writeEn = psel && penable && pwrite && state_reg.ready && !state_reg.err; // RULE24
endmodule
`default_nettype wire

// File: core/pps_port_regs.sv
// Port PHY control and status register bank behind an APB slave
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pps_port_regs
  import pps_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,
  // Cable diagnostic engine
  input wire logic cableDone,
  input wire logic [1:0] cableResult,
  input wire logic cableShortNear,
  input wire logic [FAULT_W-1:0] cableFaultCount,
  output logic cableTestActive,
  // PHY status
  input wire logic polarityReversed,
  input wire logic mdixActive,
  input wire logic rxFlowActive,
  input wire logic txFlowActive,
  input wire logic phySpeed100,
  input wire logic phyFullDuplex,
  input wire logic anFailed,
  input wire logic farEndFault,
  input wire logic anDone,
  input wire logic linkGood,
  input wire logic [ADV_W-1:0] partnerAbility,
  // LEDs
  input wire logic [3:0] ledDrive,
  output logic [3:0] portLedOutput,
  // PHY control
  output logic forceLinkPass,
  output logic powerSaveDisable,
  output logic remoteLoopback,
  output logic txDisable,
  output logic anRestart,
  output logic farEndFaultDisable,
  output logic powerDown,
  output logic autoMdixDisable,
  output logic forceMdix,
  output logic anEnable,
  output logic opSpeed100,
  output logic opFullDuplex,
  output logic [ADV_W-1:0] advertise,
  output logic crossoverAlgorithmSelect
);
  typedef struct packed {
    logic [1:0] result;
    logic shortNear;
    logic [FAULT_W-1:0] faultCount;
    logic forceLink;
    logic pwrSaveOff;
    logic loopback;
    logic ledOff;
    logic txOff;
    logic fefOff;
    logic pwrDown;
    logic mdixOff;
    logic mdixForce;
    logic anOn;
    logic forceSpeed;
    logic forceDuplex;
    logic [ADV_W-1:0] adv;
    logic xoverSel;
    logic mdixForceEff;
    logic speedOp;
    logic duplexOp;
    logic [3:0] led;
  } pps_regs_t;
  pps_regs_t state_reg;
  pps_regs_t state_next;

  logic [13:0] index;
  logic mapped;
  logic writeEn;
  logic [DATA_W-1:0] readData;
  logic [REG_W-1:0] wd;
  logic cableStartReq;
  logic restartReq;
  logic restartBit;
  logic wrDiag;
  logic wrCableView;
  logic wrSpecial;
  logic wrControl;
  logic wrStatus;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end and address decode

  assign index = paddr[ADDR_W-1:2];
  assign wd = pwdata[REG_W-1:0];

  always_comb
  begin
    mapped = (paddr[1:0] == 2'h0) &&
             ((index == IDX_CABLE_VIEW) || (index == IDX_SPECIAL_VIEW) ||
              ((index >= IDX_DIAG) && (index <= IDX_RSVD_HI)));
  end

  pps_apb_front u_front (
    .clk_sys(clk_sys),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .readData(readData),
    .mapped(mapped),
    .writeEn(writeEn)
  );

  assign wrDiag = writeEn && (index == IDX_DIAG);
  assign wrCableView = writeEn && (index == IDX_CABLE_VIEW);
  assign wrSpecial = writeEn && (index == IDX_SPECIAL_VIEW);
  assign wrControl = writeEn && (index == IDX_CONTROL);
  assign wrStatus = writeEn && (index == IDX_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Self-clearing bits

  // Writing zero cannot abort a running test; only the engine ends it
  assign cableStartReq = (wrDiag && wd[DIAG_START]) ||
                         (wrCableView && wd[CABLE_VIEW_START]); // RULE1 RULE23

  pps_sc_bit u_cable_start (
    .clk_sys(clk_sys),
    .reset(reset),
    .setReq(cableStartReq),
    .clearReq(cableDone), // RULE1
    .bitOut(cableTestActive)
  );

  // Restart lasts one cycle and then reads back as zero
  assign restartReq = wrControl && wd[CTRL_RESTART_AN]; // RULE10

  pps_sc_bit u_an_restart (
    .clk_sys(clk_sys),
    .reset(reset),
    .setReq(restartReq),
    .clearReq(restartBit),
    .bitOut(restartBit)
  );

  assign anRestart = restartBit;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    state_next = state_reg;
    if (cableDone)
    begin
      // Results stay frozen until the next test ends
      state_next.result = cableResult; // RULE2
      state_next.shortNear = cableShortNear; // RULE3
      state_next.faultCount = cableFaultCount; // RULE4
    end
    if (wrDiag)
    begin
      state_next.forceLink = wd[DIAG_FORCE_LINK]; // RULE5
      state_next.pwrSaveOff = wd[DIAG_PWR_SAVE]; // RULE6
      state_next.loopback = wd[DIAG_LOOPBACK]; // RULE7
    end
    if (wrSpecial)
    begin
      state_next.forceLink = wd[SPECIAL_FORCE_LINK]; // RULE23
      state_next.pwrSaveOff = wd[SPECIAL_PWR_SAVE]; // RULE23
      state_next.loopback = wd[SPECIAL_LOOPBACK]; // RULE23
    end
    if (wrControl)
    begin
      state_next.ledOff = wd[CTRL_LED_OFF]; // RULE8
      state_next.txOff = wd[CTRL_TX_DISABLE]; // RULE9
      state_next.fefOff = wd[CTRL_FEF_DISABLE]; // RULE11
      state_next.pwrDown = wd[CTRL_POWER_DOWN]; // RULE9
      state_next.mdixOff = wd[CTRL_MDIX_DISABLE]; // RULE12
      state_next.mdixForce = wd[CTRL_FORCE_MDIX]; // RULE12
      state_next.anOn = wd[CTRL_AN_ENABLE]; // RULE13
      state_next.forceSpeed = wd[CTRL_FORCE_SPEED]; // RULE14
      state_next.forceDuplex = wd[CTRL_FORCE_DUPLEX]; // RULE15
      state_next.adv = wd[ADV_MSB:0]; // RULE16
    end
    if (wrStatus)
    begin
      // Only the algorithm select is writable in the status word
      state_next.xoverSel = wd[STAT_XOVER_SEL]; // RULE17 RULE24
    end
    // Force MDIX is honoured only while auto crossover is off
    state_next.mdixForceEff = state_next.mdixOff && state_next.mdixForce; // RULE12
    state_next.speedOp = state_next.anOn ? phySpeed100 : state_next.forceSpeed; // RULE13 RULE14
    state_next.duplexOp = (state_next.anOn && !anFailed) ? phyFullDuplex
                                                          : state_next.forceDuplex; // RULE15
    state_next.led = state_next.ledOff ? LED_ALL_OFF : ledDrive; // RULE8
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg <= '0;
      state_reg.pwrSaveOff <= DIAG_RESET[DIAG_PWR_SAVE]; // RULE6
      state_reg.anOn <= CONTROL_RESET[CTRL_AN_ENABLE]; // RULE13
      state_reg.adv <= CONTROL_RESET[ADV_MSB:0]; // RULE16
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb
  begin
    readData = READ_ZERO;
    case (index)
      IDX_DIAG:
      begin
        readData[REG_W-1:0] = {state_reg.shortNear, state_reg.result, cableTestActive,
                               state_reg.forceLink, state_reg.pwrSaveOff,
                               state_reg.loopback, state_reg.faultCount};
      end
      IDX_CABLE_VIEW:
      begin
        readData[REG_W-1:0] = {cableTestActive, state_reg.result, state_reg.shortNear,
                               3'h0, state_reg.faultCount}; // RULE23
      end
      IDX_SPECIAL_VIEW:
      begin
        readData[REG_W-1:0] = {10'h000, polarityReversed, mdixActive,
                               state_reg.forceLink, state_reg.pwrSaveOff,
                               state_reg.loopback, 1'b0}; // RULE23
      end
      IDX_CONTROL:
      begin
        readData[REG_W-1:0] = {state_reg.ledOff, state_reg.txOff, restartBit,
                               state_reg.fefOff, state_reg.pwrDown, state_reg.mdixOff,
                               state_reg.mdixForce, 1'b0, state_reg.anOn,
                               state_reg.forceSpeed, state_reg.forceDuplex, state_reg.adv};
      end
      IDX_STATUS:
      begin
        readData[REG_W-1:0] = {state_reg.xoverSel, 1'b0, polarityReversed, // RULE18
                               rxFlowActive, txFlowActive, // RULE19
                               state_reg.speedOp, state_reg.duplexOp, // RULE20
                               farEndFault, mdixActive, anDone, linkGood, // RULE21
                               partnerAbility}; // RULE22
      end
      default:
      begin
        // Reserved words above the status register read as zero
        readData = READ_ZERO; // RULE24
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign forceLinkPass = state_reg.forceLink;
  assign powerSaveDisable = state_reg.pwrSaveOff;
  assign remoteLoopback = state_reg.loopback;
  assign txDisable = state_reg.txOff;
  assign farEndFaultDisable = state_reg.fefOff;
  assign powerDown = state_reg.pwrDown;
  assign autoMdixDisable = state_reg.mdixOff;
  assign forceMdix = state_reg.mdixForceEff;
  assign anEnable = state_reg.anOn;
  assign opSpeed100 = state_reg.speedOp;
  assign opFullDuplex = state_reg.duplexOp;
  assign advertise = state_reg.adv;
  assign crossoverAlgorithmSelect = state_reg.xoverSel;
  assign portLedOutput = state_reg.led;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  cableStarts_a: // RULE1
  assert property (@(posedge clk_sys) disable iff (reset)
    (wrDiag && wd[DIAG_START]) |=> cableTestActive)
    else $error("cable test did not start on write");

  cableEnds_a: // RULE1
  assert property (@(posedge clk_sys) disable iff (reset)
    (cableDone && !cableStartReq) |=> !cableTestActive)
    else $error("cable test bit not cleared at end of test");

  resultCapture_a: // RULE2
  assert property (@(posedge clk_sys) disable iff (reset)
    cableDone |=> (state_reg.result == $past(cableResult)) &&
                  (state_reg.faultCount == $past(cableFaultCount)))
    else $error("cable results not captured");

  ledOff_a: // RULE8
  assert property (@(posedge clk_sys) disable iff (reset)
    (wrControl && wd[CTRL_LED_OFF]) |=> ##1 (portLedOutput == LED_ALL_OFF))
    else $error("LEDs not driven high when switched off");

  restartPulse_a: // RULE10
  assert property (@(posedge clk_sys) disable iff (reset)
    restartReq |=> anRestart ##1 !anRestart)
    else $error("restart is not a single pulse");

  mdixForce_a: // RULE12
  assert property (@(posedge clk_sys) disable iff (reset)
    forceMdix |-> autoMdixDisable)
    else $error("MDIX forced while auto crossover enabled");

  speedForced_a: // RULE14
  assert property (@(posedge clk_sys) disable iff (reset)
    (!state_next.anOn) |=> (opSpeed100 == $past(state_next.forceSpeed)))
    else $error("forced speed not applied");

  defaults_a: // RULE16
  assert property (@(posedge clk_sys)
    $past(reset) |-> (advertise == ADV_ALL) && anEnable && powerSaveDisable)
    else $error("reset defaults wrong");

  aliasView_a: // RULE23
  assert property (@(posedge clk_sys) disable iff (reset)
    wrSpecial |=> (forceLinkPass == $past(wd[SPECIAL_FORCE_LINK])))
    else $error("special view write not seen by diagnostic state");

  reservedZero_a: // RULE24
  assert property (@(posedge clk_sys) disable iff (reset)
    (psel && !penable && mapped && (index >= IDX_RSVD_LO)) |=> (prdata == READ_ZERO))
    else $error("reserved location read nonzero");
endmodule
`default_nettype wire

// File: sim/pps_port_regs_tb_top.sv
// Self-checking bench for the port PHY control and status register bank
`timescale 1ns/1ps
`default_nettype none
module pps_port_regs_tb_top
  import pps_pkg::*;
;
////////////////////////////////////////
logic clk_sys = 1'b0;
logic reset = 1'b1;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [ADDR_W-1:0] paddr = 16'h0000;
logic [DATA_W-1:0] pwdata = 32'h0000_0000;
logic cableDone = 1'b0;
logic [1:0] cableResult = 2'h0;
logic cableShortNear = 1'b0;
logic [FAULT_W-1:0] cableFaultCount = 9'h000;
// Speed100, full, anFailed, pol, rxfc, txfc, fef, mdix, anDone, link
logic [9:0] phy = 10'h000;
logic [ADV_W-1:0] partner = 5'h00;
logic [3:0] led = 4'h0;
logic [15:0] dg = 16'h0400;
wire pready;
wire pslverr;
wire [DATA_W-1:0] prdata;
wire cableTestActive;
wire [12:0] ctl;
wire [ADV_W-1:0] advertise;
wire [3:0] ledOut;
int failCount = 0;
int cmpCount = 0;
always #10 clk_sys = ~clk_sys;
pps_port_regs u_dut (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .cableDone(cableDone),
  .cableResult(cableResult), .cableShortNear(cableShortNear),
  .cableFaultCount(cableFaultCount), .cableTestActive(cableTestActive),
  .polarityReversed(phy[6]), .mdixActive(phy[2]), .rxFlowActive(phy[5]),
  .txFlowActive(phy[4]), .phySpeed100(phy[9]), .phyFullDuplex(phy[8]),
  .anFailed(phy[7]), .farEndFault(phy[3]), .anDone(phy[1]), .linkGood(phy[0]),
  .partnerAbility(partner), .ledDrive(led), .portLedOutput(ledOut),
  .forceLinkPass(ctl[0]), .powerSaveDisable(ctl[1]), .remoteLoopback(ctl[2]),
  .txDisable(ctl[3]), .anRestart(ctl[4]), .farEndFaultDisable(ctl[5]),
  .powerDown(ctl[6]), .autoMdixDisable(ctl[7]), .forceMdix(ctl[8]),
  .anEnable(ctl[9]), .opSpeed100(ctl[10]), .opFullDuplex(ctl[11]),
  .advertise(advertise), .crossoverAlgorithmSelect(ctl[12])
);
////////////////////////////////////////
task automatic endOfTest;
  if (failCount == 0 && cmpCount > 0)
    $display("TEST PASSED");
  else
    $display("TEST FAILED");
  $finish;
endtask

task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
  cmpCount++;
  if (g !== e)
  begin
    failCount++;
    $display("mismatch %s expected %h seen %h", nm, e, g);
  end
endtask

// Request is held until pready is sampled high; no fixed latency assumed
task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] d,
  output logic [31:0] q, output logic err);
  @(posedge clk_sys);
  psel <= 1'b1;
  penable <= 1'b0;
  pwrite <= w;
  paddr <= {idx, 2'b00};
  pwdata <= d;
  @(posedge clk_sys);
  penable <= 1'b1;
  // Only the watchdog ends a wait that never sees pready
  do
  begin
    @(posedge clk_sys);
  end
  while (pready !== 1'b1);
  q = prdata;
  err = pslverr;
  psel <= 1'b0;
  penable <= 1'b0;
endtask

task automatic wr(input logic [13:0] idx, input logic [31:0] d);
  logic [31:0] q;
  logic e;
  apb(1'b1, idx, d, q, e);
  chk("wrErr", 32'h0000_0000, 32'(e));
endtask

task automatic rd(input logic [13:0] idx, input logic [31:0] x, input string nm);
  logic [31:0] q;
  logic e;
  apb(1'b0, idx, 32'h0000_0000, q, e);
  chk(nm, x, q);
endtask

// Outputs may lag the register by a flop stage, so allow a few edges
task automatic settle;
  repeat (3) @(posedge clk_sys);
  #1;
endtask
////////////////////////////////////////
task automatic t_reset;
  rd(IDX_DIAG, 32'h0000_0400, "diagRst");
  rd(IDX_CONTROL, 32'h0000_009F, "ctrlRst");
  rd(IDX_SPECIAL_VIEW, 32'h0000_0004, "specRst");
  chk("advRst", 32'h0000_001F, 32'(advertise));
  chk("ctlRst", 32'h0000_0202, 32'(ctl));
endtask

task automatic t_cable;
  logic [1:0] r;
  logic [8:0] c;
  for (int i = 0; i < 4; i++)
  begin
    r = 2'(i);
    c = 9'h1FF >> (2 * i);
    // Odd passes start through the cable view alias
    wr(r[0] ? IDX_CABLE_VIEW : IDX_DIAG, r[0] ? 32'h0000_8000 : 32'h0000_1400);
    settle;
    chk("active", 32'h0000_0001, 32'(cableTestActive));
    rd(IDX_DIAG, 32'(dg | 16'h1000), "diagBusy");
    wr(IDX_DIAG, 32'h0000_0400);
    settle;
    chk("noAbort", 32'h0000_0001, 32'(cableTestActive));
    @(posedge clk_sys);
    cableDone <= 1'b1;
    cableResult <= r;
    cableShortNear <= r[1];
    cableFaultCount <= c;
    @(posedge clk_sys);
    cableDone <= 1'b0;
    dg = {r[1], r, 1'b0, 3'b010, c};
    settle;
    chk("idle", 32'h0000_0000, 32'(cableTestActive));
    rd(IDX_DIAG, 32'(dg), "diagRes");
    rd(IDX_CABLE_VIEW, 32'({1'b0, r, r[1], 3'b000, c}), "cableView");
  end
endtask

task automatic t_diag;
  wr(IDX_DIAG, 32'h0000_0A00);
  settle;
  chk("diagOut", 32'h0000_0005, 32'(ctl[2:0]));
  rd(IDX_SPECIAL_VIEW, 32'h0000_000A, "specView");
  wr(IDX_SPECIAL_VIEW, 32'h0000_0005);
  rd(IDX_DIAG, 32'(dg), "diagAlias");
  settle;
  chk("diagOut2", 32'h0000_0002, 32'(ctl[2:0]));
endtask

task automatic t_ctrl;
  int n = 0;
  @(posedge clk_sys);
  led <= 4'h5;
  wr(IDX_CONTROL, 32'h0000_DC9F);
  settle;
  chk("ledOff", 32'h0000_000F, 32'(ledOut));
  chk("ctlSet", 32'h0000_02EA, 32'(ctl));
  wr(IDX_CONTROL, 32'h0000_029F);
  settle;
  chk("ledOn", 32'h0000_0005, 32'(ledOut));
  chk("mdixAuto", 32'h0000_0202, 32'(ctl));
  wr(IDX_CONTROL, 32'h0000_069F);
  settle;
  chk("mdixForce", 32'h0000_0382, 32'(ctl));
  wr(IDX_CONTROL, 32'h0000_209F);
  repeat (6)
  begin
    #1;
    n += (ctl[4] === 1'b1);
    @(posedge clk_sys);
  end
  chk("restartPulse", 32'h0000_0001, 32'(n));
  rd(IDX_CONTROL, 32'h0000_009F, "restartRd");
endtask

task automatic t_an;
  @(posedge clk_sys);
  phy <= 10'h100;
  wr(IDX_CONTROL, 32'h0000_0060);
  settle;
  chk("forced", 32'h0000_0003, 32'(ctl[11:10]));
  chk("advOff", 32'h0000_0000, 32'({ctl[9], advertise}));
  wr(IDX_CONTROL, 32'h0000_0040);
  settle;
  chk("forcedHalf", 32'h0000_0001, 32'(ctl[11:10]));
  wr(IDX_CONTROL, 32'h0000_0020);
  settle;
  chk("forced10", 32'h0000_0002, 32'(ctl[11:10]));
  @(posedge clk_sys);
  phy <= 10'h080;
  wr(IDX_CONTROL, 32'h0000_00A0);
  settle;
  chk("anFail", 32'h0000_0002, 32'(ctl[11:10]));
  @(posedge clk_sys);
  phy <= 10'h000;
  settle;
  chk("anOk", 32'h0000_0000, 32'(ctl[11:10]));
  wr(IDX_CONTROL, 32'h0000_0095);
  settle;
  chk("adv", 32'h0000_0015, 32'(advertise));
endtask

task automatic t_stat;
  logic [9:0] p;
  logic [15:0] x;
  wr(IDX_STATUS, 32'h0000_FFFF);
  settle;
  chk("xoverSet", 32'h0000_0001, 32'(ctl[12]));
  for (int i = 0; i < 2; i++)
  begin
    p = i ? 10'h14A : 10'h2B5;
    @(posedge clk_sys);
    phy <= p;
    partner <= i ? 5'h0A : 5'h15;
    settle;
    // Duplex falls back to the forced bit (clear) when negotiation failed
    x = {2'b10, p[6:4], p[9], p[7] ? 1'b0 : p[8], p[3:0], i ? 5'h0A : 5'h15};
    rd(IDX_STATUS, 32'(x), "status");
    rd(IDX_SPECIAL_VIEW, 32'({p[6], p[2], 4'h4}), "specStat");
  end
  wr(IDX_STATUS, 32'h0000_7FFF);
  settle;
  chk("xoverClr", 32'h0000_0000, 32'(ctl[12]));
endtask

task automatic t_rsvd;
  logic [31:0] q;
  logic e;
  wr(IDX_RSVD_LO, 32'h0000_FFFF);
  rd(IDX_RSVD_LO, 32'h0000_0000, "rsvdLo");
  wr(IDX_RSVD_HI, 32'h0000_FFFF);
  rd(IDX_RSVD_HI, 32'h0000_0000, "rsvdHi");
  apb(1'b0, 14'h0100, 32'h0000_0000, q, e);
  chk("unmapErr", 32'h0000_0001, 32'(e));
  chk("unmapData", 32'h0000_0000, q);
endtask
////////////////////////////////////////
initial
begin
  repeat (3) @(posedge clk_sys);
  reset <= 1'b0;
  t_reset;
  t_cable;
  t_diag;
  t_ctrl;
  t_an;
  t_stat;
  t_rsvd;
  endOfTest;
end

// Whole run needs well under a tenth of this span
initial
begin
  #400000;
  failCount++;
  endOfTest;
end
endmodule
`default_nettype wire
